// ==== rtl/intc_regs.svh ====
// register offsets, field positions, reset values and timing counts of the interrupt controller
`ifndef INTC_REGS_SVH
`define INTC_REGS_SVH

// register byte offsets
`define NODE_CTL_BASE      12'h000
`define NODE_CTL_LAST      12'h03c
`define GLOBAL_CTL_OFS     12'h040
`define VEC_SEG_OFS        12'h044
`define STATUS_OFS         12'h048
`define CHAN_BASE          12'h080
`define CHAN_LAST          12'h0fc
`define CHAN_SRC_SUB       2'h0
`define CHAN_DST_SUB       2'h1
`define CHAN_CNT_SUB       2'h2
`define CHAN_CFG_SUB       2'h3

// node control fields
`define NODE_LVL_LSB       0
`define NODE_EN_BIT        6
`define NODE_REQ_BIT       7
`define NODE_SVC_BIT       8
`define NODE_CHAN_LSB      9

// global control fields
`define GCTL_SPACING_LSB   0
`define GCTL_SHARED_BIT    2
`define GCTL_EXT0_LSB      4
`define GCTL_EXT1_LSB      6

// channel config fields
`define CFG_INC_SRC_BIT    0
`define CFG_INC_DST_BIT    1
`define CFG_WORD_BIT       2
`define CFG_CONT_BIT       3

// reset values
`define GCTL_RESET         8'h00
`define VEC_SEG_RESET      8'h00

// trap number of node 0; node n has trap number base plus n
`define NODE_TRAP_BASE     8'h10
// least vector spacing is four bytes, a shift of two
`define VEC_SHIFT_MIN      3'h2

// response budget in cpu clocks, with and without the jump cache
`define RESP_CACHE_CLKS    7
`define RESP_NOCACHE_CLKS  11

`endif

// ==== rtl/intc_pkg.sv ====
// types shared by the interrupt controller and its event transfer engine
package intc_pkg;

   typedef enum logic [1:0] {
      EDGE_OFF  = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_BOTH = 2'b11
   } edge_mode_e;

   typedef enum logic [0:0] {
      XFER_IDLE = 1'b0,
      XFER_BUSY = 1'b1
   } xfer_state_e;

   typedef enum logic [2:0] {
      DEC_NONE = 3'b000,
      DEC_NODE = 3'b001,
      DEC_GCTL = 3'b010,
      DEC_SEG  = 3'b011,
      DEC_STAT = 3'b100,
      DEC_CHAN = 3'b101
   } dec_kind_e;

   typedef struct packed {
      dec_kind_e  kind;
      logic [3:0] index;
      logic [1:0] sub;
   } dec_s;

   typedef struct packed {
      logic [2:0] chan;
      logic       svc;
      logic       req;
      logic       en;
      logic [3:0] lvl;
   } node_ctl_s;

   typedef struct packed {
      logic cont;
      logic word;
      logic inc_dst;
      logic inc_src;
   } chan_cfg_s;

endpackage : intc_pkg

// ==== rtl/edge_detect.sv ====
// synchroniser and programmable edge detector for the fast external interrupt pins
module edge_detect
   import intc_pkg::*;
(
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // pins and modes
   input  wire logic [1:0] i_pin,
   input  wire logic [3:0] i_mode,
   // one-cycle events
   output logic      [1:0] o_evt
);

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_pin
         logic       meta;
         logic       sync;
         logic       prev;
         edge_mode_e mode;

         assign mode = edge_mode_e'(i_mode[2*g+1:2*g]);

         // two flops before any logic; only the second is compared
         always_ff @(posedge i_clk) begin
            if (i_rst) begin
               meta <= 1'b0;
               sync <= 1'b0;
               prev <= 1'b0;
            end else begin
               meta <= i_pin[g];
               sync <= meta;
               prev <= sync;
            end
         end

         // rising, falling or both edges raise one event
         always_ff @(posedge i_clk) begin
            if (i_rst) begin
               o_evt[g] <= 1'b0;
            end else begin
               case (mode)
                  EDGE_RISE: o_evt[g] <= sync & ~prev;
                  EDGE_FALL: o_evt[g] <= ~sync & prev;
                  EDGE_BOTH: o_evt[g] <= sync ^ prev;
                  default:   o_evt[g] <= 1'b0;
               endcase
            end
         end
      end
   endgenerate

endmodule : edge_detect

// ==== rtl/node_arbiter.sv ====
// picks the highest pending level among the nodes, lower index winning a tie
module node_arbiter
   import intc_pkg::*;
(
   // pending nodes and their levels
   input  wire logic [15:0]      i_pend,
   input  wire logic [15:0][3:0] i_lvl,
   // winner
   output logic                  o_valid,
   output logic      [3:0]       o_idx,
   output logic      [3:0]       o_lvl
);

   // scan upward; strictly greater keeps the lower index on a tie
   always_comb begin
      o_valid = 1'b0;
      o_idx   = 4'h0;
      o_lvl   = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (i_pend[i] && (!o_valid || i_lvl[i] > o_lvl)) begin
            o_valid = 1'b1;
            o_idx   = 4'(i);
            o_lvl   = i_lvl[i];
         end
      end
   end

endmodule : node_arbiter

// ==== rtl/intc_top.sv ====
// prioritised vectored interrupt controller with eight-channel event transfer engine
//
// Operation
// - accepted request reaches the cpu well inside 7 or 11 clocks
// - each node chooses vectored interrupt or single event transfer service
// - an event transfer steals one cpu cycle, no suspension, no vector
// - transfer moves one byte or word, then bumps source, destination or both
// - counter decrements per transfer, held in continuous mode
// - counter reaching zero turns the request into a standard interrupt
// - eight channels, each with source, destination and counter
// - every node has a control register: request, enable, priority
// - sixteen priority levels decide arbitration among pending requests
// - a running service is preempted only by a strictly higher level
// - each node has its own vector location
// - fast external pins detect rising, falling or both edges
// - software trap number yields the same vector as that hardware node
// - software may set a node request flag to raise an interrupt
// - default vector offset is four times the trap number
// - node 14 is shared between two selectable sources
// - vectors without a control register have no hardware source
// - a field sets vector spacing, four bytes by default
// - a segment register supplies the upper vector address bits
//
// The APB slave port and the register offsets were chosen for this implementation.
`include "intc_regs.svh"

module intc_top
   import intc_pkg::*;
(
   // clock and reset
   input  wire logic        I_REF_CLK,
   input  wire logic        I_RST,
   // apb slave
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [11:0] I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic             O_PREADY,
   output logic      [31:0] O_PRDATA,
   output logic             O_PSLVERR,
   // request sources
   input  wire logic [15:0] I_SRC_REQ,
   input  wire logic        I_ALT_REQ,
   input  wire logic [1:0]  I_EXT_PIN,
   // cpu interrupt port
   output logic             O_IRQ_REQ,
   output logic      [23:0] O_IRQ_VECTOR,
   output logic      [7:0]  O_IRQ_TRAP,
   output logic      [3:0]  O_IRQ_LEVEL,
   input  wire logic        I_IRQ_ACK,
   input  wire logic        I_IRQ_RETURN,
   // software trap
   input  wire logic        I_SWTRAP_VALID,
   input  wire logic [7:0]  I_SWTRAP_NUM,
   output logic             O_SWTRAP_VALID,
   output logic      [23:0] O_SWTRAP_VECTOR,
   // cycle steal port of the event transfer engine
   output logic             O_STEAL_REQ,
   output logic      [23:0] O_STEAL_SRC,
   output logic      [23:0] O_STEAL_DST,
   output logic             O_STEAL_WORD,
   input  wire logic        I_STEAL_DONE
);

   ////////////////////////////////////////////////////////////////////////////////
   // functions

   // register decode, shared by read and write paths
   function automatic dec_s decode(input logic [11:0] a);
      dec_s d;
      d.kind  = DEC_NONE;
      d.index = a[5:2];
      d.sub   = a[3:2];
      if (a[1:0] != 2'b00) begin
         d.kind = DEC_NONE;
      end else if (a <= `NODE_CTL_LAST) begin
         d.kind = DEC_NODE;
      end else if (a == `GLOBAL_CTL_OFS) begin
         d.kind = DEC_GCTL;
      end else if (a == `VEC_SEG_OFS) begin
         d.kind = DEC_SEG;
      end else if (a == `STATUS_OFS) begin
         d.kind = DEC_STAT;
      end else if (a >= `CHAN_BASE && a <= `CHAN_LAST) begin
         d.kind  = DEC_CHAN;
         d.index = {1'b0, a[6:4]};
      end
      return d;
   endfunction : decode

   // vector address: segment on top, trap number scaled by the spacing
   function automatic logic [23:0] vector_of(input logic [7:0] trap,
                                              input logic [1:0] spacing,
                                              input logic [7:0] seg);
      logic [15:0] ofs;
      ofs = {8'h00, trap} << (`VEC_SHIFT_MIN + {1'b0, spacing});
      return {seg, ofs};
   endfunction : vector_of

   // highest active level, zero when nothing runs
   function automatic logic [3:0] top_level(input logic [15:0] act);
      logic [3:0] l;
      l = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (act[i]) begin
            l = 4'(i);
         end
      end
      return l;
   endfunction : top_level

   ////////////////////////////////////////////////////////////////////////////////
   // storage and wires

   node_ctl_s        node [16];
   logic [7:0]       gctl;
   logic [7:0]       vec_seg;
   logic [23:0]      chan_src [8];
   logic [23:0]      chan_dst [8];
   logic [7:0]       chan_cnt [8];
   chan_cfg_s        chan_cfg [8];
   logic [15:0]      active;
   logic [15:0]      next_active;
   xfer_state_e      xfer_state;
   logic [3:0]       xfer_node;
   logic [2:0]       xfer_chan;
   logic [1:0]       ext_evt;
   logic [15:0]      src_evt;
   logic [15:0]      pend;
   logic [15:0][3:0] lvls;
   logic [15:0]      req_clr;
   logic             win_valid;
   logic [3:0]       win_idx;
   logic [3:0]       win_lvl;
   logic [3:0]       cur_lvl;
   logic             win_ok;
   logic             win_xfer;
   dec_s             dec;
   logic             apb_wr;
   logic             apb_rd;
   logic [31:0]      rd_mux;

   assign dec    = decode(I_PADDR);
   assign apb_wr = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
   assign apb_rd = I_PSEL & I_PENABLE & ~O_PREADY;

   ////////////////////////////////////////////////////////////////////////////////
   // sources

   edge_detect u_edge (
      .i_clk  (I_REF_CLK),
      .i_rst  (I_RST),
      .i_pin  (I_EXT_PIN),
      .i_mode (gctl[7:4]),
      .o_evt  (ext_evt)
   );

   // pins join nodes 0 and 1; node 14 takes one of two sources
   always_comb begin
      src_evt     = I_SRC_REQ;
      src_evt[0]  = I_SRC_REQ[0] | ext_evt[0];
      src_evt[1]  = I_SRC_REQ[1] | ext_evt[1];
      src_evt[14] = gctl[`GCTL_SHARED_BIT] ? I_ALT_REQ : I_SRC_REQ[14];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // node control registers; a hardware set beats any clear in the same cycle

   genvar n;
   generate
      for (n = 0; n < 16; n++) begin : g_node
         assign pend[n] = node[n].req & node[n].en;
         assign lvls[n] = node[n].lvl;

         always_ff @(posedge I_REF_CLK) begin
            if (I_RST) begin
               node[n] <= '0;
            end else begin
               if (apb_wr && dec.kind == DEC_NODE && dec.index == 4'(n)) begin
                  node[n] <= {I_PWDATA[`NODE_CHAN_LSB+2:`NODE_EN_BIT], I_PWDATA[3:0]};
               end
               if (req_clr[n]) begin
                  node[n].req <= 1'b0;
               end
               if (src_evt[n]) begin
                  node[n].req <= 1'b1;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // arbitration

   node_arbiter u_arb (
      .i_pend  (pend),
      .i_lvl   (lvls),
      .o_valid (win_valid),
      .o_idx   (win_idx),
      .o_lvl   (win_lvl)
   );

   assign cur_lvl  = top_level(active);
   assign win_ok   = win_valid && (win_lvl > cur_lvl);
   // transfer service only while the counter runs or in continuous mode
   assign win_xfer = node[win_idx].svc &&
                     (chan_cnt[node[win_idx].chan] != 8'h00 ||
                      chan_cfg[node[win_idx].chan].cont);

   // flags dropped on cpu acceptance or on a finished transfer that does not empty the counter
   always_comb begin
      req_clr = '0;
      if (I_IRQ_ACK && O_IRQ_REQ) begin
         req_clr[O_IRQ_TRAP[3:0]] = 1'b1;
      end
      if (xfer_state == XFER_BUSY && I_STEAL_DONE &&
          (chan_cfg[xfer_chan].cont || chan_cnt[xfer_chan] != 8'h01)) begin
         req_clr[xfer_node] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // cpu offer, registered one cycle after arbitration

   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         O_IRQ_REQ    <= 1'b0;
         O_IRQ_VECTOR <= 24'h000000;
         O_IRQ_TRAP   <= 8'h00;
         O_IRQ_LEVEL  <= 4'h0;
      end else begin
         // withdrawn in the ack cycle so the cleared node is not offered twice
         O_IRQ_REQ    <= win_ok && !win_xfer && !(I_IRQ_ACK && O_IRQ_REQ);
         O_IRQ_TRAP   <= `NODE_TRAP_BASE + {4'h0, win_idx};
         O_IRQ_LEVEL  <= win_lvl;
         O_IRQ_VECTOR <= vector_of(`NODE_TRAP_BASE + {4'h0, win_idx},
                                   gctl[1:0], vec_seg);
      end
   end

   // levels of nested services; return pops the top one, ack pushes
   always_comb begin
      next_active = active;
      if (I_IRQ_RETURN) begin
         next_active[cur_lvl] = 1'b0;
      end
      if (I_IRQ_ACK && O_IRQ_REQ) begin
         next_active[O_IRQ_LEVEL] = 1'b1;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         active <= 16'h0000;
      end else begin
         active <= next_active;
      end
   end

   // software trap enters exactly as the hardware node of that number
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         O_SWTRAP_VALID  <= 1'b0;
         O_SWTRAP_VECTOR <= 24'h000000;
      end else begin
         O_SWTRAP_VALID  <= I_SWTRAP_VALID;
         O_SWTRAP_VECTOR <= vector_of(I_SWTRAP_NUM, gctl[1:0], vec_seg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // event transfer engine: one stolen cycle per move, program keeps running

   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         xfer_state   <= XFER_IDLE;
         xfer_node    <= 4'h0;
         xfer_chan    <= 3'h0;
         O_STEAL_REQ  <= 1'b0;
         O_STEAL_SRC  <= 24'h000000;
         O_STEAL_DST  <= 24'h000000;
         O_STEAL_WORD <= 1'b0;
      end else begin
         case (xfer_state)
            XFER_IDLE: begin
               if (win_ok && win_xfer) begin
                  xfer_state   <= XFER_BUSY;
                  xfer_node    <= win_idx;
                  xfer_chan    <= node[win_idx].chan;
                  O_STEAL_REQ  <= 1'b1;
                  O_STEAL_SRC  <= chan_src[node[win_idx].chan];
                  O_STEAL_DST  <= chan_dst[node[win_idx].chan];
                  O_STEAL_WORD <= chan_cfg[node[win_idx].chan].word;
               end
            end
            XFER_BUSY: begin
               if (I_STEAL_DONE) begin
                  xfer_state  <= XFER_IDLE;
                  O_STEAL_REQ <= 1'b0;
               end
            end
            default: xfer_state <= XFER_IDLE;
         endcase
      end
   end

   // channel registers, software writes first, hardware update after wins
   genvar c;
   generate
      for (c = 0; c < 8; c++) begin : g_chan
         logic        done;
         logic [23:0] step;
         assign done = xfer_state == XFER_BUSY && I_STEAL_DONE && xfer_chan == 3'(c);
         assign step = chan_cfg[c].word ? 24'h000002 : 24'h000001;

         always_ff @(posedge I_REF_CLK) begin
            if (I_RST) begin
               chan_src[c] <= 24'h000000;
               chan_dst[c] <= 24'h000000;
               chan_cnt[c] <= 8'h00;
               chan_cfg[c] <= '0;
            end else begin
               if (apb_wr && dec.kind == DEC_CHAN && dec.index[2:0] == 3'(c)) begin
                  if (dec.sub == `CHAN_SRC_SUB) chan_src[c] <= I_PWDATA[23:0];
                  if (dec.sub == `CHAN_DST_SUB) chan_dst[c] <= I_PWDATA[23:0];
                  if (dec.sub == `CHAN_CNT_SUB) chan_cnt[c] <= I_PWDATA[7:0];
                  if (dec.sub == `CHAN_CFG_SUB) chan_cfg[c] <= I_PWDATA[3:0];
               end
               if (done) begin
                  if (chan_cfg[c].inc_src) chan_src[c] <= chan_src[c] + step;
                  if (chan_cfg[c].inc_dst) chan_dst[c] <= chan_dst[c] + step;
                  if (!chan_cfg[c].cont) chan_cnt[c] <= chan_cnt[c] - 8'h01;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, read data and ready from flops

   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         gctl    <= `GCTL_RESET;
         vec_seg <= `VEC_SEG_RESET;
      end else if (apb_wr) begin
         if (dec.kind == DEC_GCTL) gctl <= I_PWDATA[7:0];
         if (dec.kind == DEC_SEG) vec_seg <= I_PWDATA[7:0];
      end
   end

   always_comb begin
      rd_mux = 32'h00000000;
      if (dec.kind == DEC_NODE) begin
         rd_mux = {20'h00000, node[dec.index][9:4], 2'b00, node[dec.index][3:0]};
      end else if (dec.kind == DEC_GCTL) begin
         rd_mux = {24'h000000, gctl};
      end else if (dec.kind == DEC_SEG) begin
         rd_mux = {24'h000000, vec_seg};
      end else if (dec.kind == DEC_STAT) begin
         rd_mux = {26'h0000000, xfer_state == XFER_BUSY, active != 16'h0000, cur_lvl};
      end else if (dec.kind == DEC_CHAN) begin
         case (dec.sub)
            `CHAN_SRC_SUB: rd_mux = {8'h00, chan_src[dec.index[2:0]]};
            `CHAN_DST_SUB: rd_mux = {8'h00, chan_dst[dec.index[2:0]]};
            `CHAN_CNT_SUB: rd_mux = {24'h000000, chan_cnt[dec.index[2:0]]};
            default:       rd_mux = {28'h0000000, chan_cfg[dec.index[2:0]]};
         endcase
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         O_PREADY  <= 1'b0;
         O_PRDATA  <= 32'h00000000;
         O_PSLVERR <= 1'b0;
      end else begin
         O_PREADY  <= apb_rd;
         O_PSLVERR <= apb_rd && dec.kind == DEC_NONE;
         if (apb_rd) begin
            O_PRDATA <= I_PWRITE ? 32'h00000000 : rd_mux;
         end
      end
   end

endmodule : intc_top

// ==== test/intc_checker.sv ====
// port assertions of the interrupt controller, bound to its top module
module intc_checker
   import intc_pkg::*;
(
   // clock and reset
   input wire logic        I_REF_CLK,
   input wire logic        I_RST,
   // register bus
   input wire logic        I_PSEL,
   input wire logic        I_PENABLE,
   input wire logic [11:0] I_PADDR,
   input wire logic        O_PREADY,
   input wire logic        O_PSLVERR,
   // cpu side
   input wire logic        O_IRQ_REQ,
   input wire logic [7:0]  O_IRQ_TRAP,
   input wire logic [3:0]  O_IRQ_LEVEL,
   input wire logic        I_IRQ_ACK,
   input wire logic        I_SWTRAP_VALID,
   input wire logic        O_SWTRAP_VALID,
   // cycle steal
   input wire logic        O_STEAL_REQ,
   input wire logic [23:0] O_STEAL_SRC,
   input wire logic [23:0] O_STEAL_DST,
   input wire logic        I_STEAL_DONE
);
   default clocking cb @(posedge I_REF_CLK);
   endclocking
   default disable iff (I_RST);

   ////////////////////////////////////////////////////////////////////////////////
   // one wait state, then a single ready cycle
   a_apb_one_wait: assert property (I_PSEL && !I_PENABLE |=> !O_PREADY ##1 O_PREADY)
      else $error("ready not in second access cycle");
   a_ready_once: assert property (O_PREADY |=> !O_PREADY)
      else $error("ready held too long");
   a_gap_refused: assert property (O_PREADY && I_PADDR > 12'h048 && I_PADDR < 12'h080
      |-> O_PSLVERR)
      else $error("unmapped access not refused");
   // offers carry a real level and a node with its own register
   a_offer_level: assert property (O_IRQ_REQ |-> O_IRQ_LEVEL != 4'h0)
      else $error("level zero offered");
   a_offer_node: assert property (O_IRQ_REQ |-> O_IRQ_TRAP[7:4] == 4'h1)
      else $error("trap outside node range");
   a_ack_drops: assert property (O_IRQ_REQ && I_IRQ_ACK |=> !O_IRQ_REQ)
      else $error("offer held after ack");
   a_swtrap_next: assert property (I_SWTRAP_VALID |=> O_SWTRAP_VALID)
      else $error("software trap not answered");
   // a move is held steady, then ends one cycle after done
   a_steal_hold: assert property (O_STEAL_REQ && !I_STEAL_DONE |=>
      O_STEAL_REQ && $stable(O_STEAL_SRC) && $stable(O_STEAL_DST))
      else $error("steal request changed while waiting");
   a_steal_single: assert property (O_STEAL_REQ && I_STEAL_DONE |=> !O_STEAL_REQ)
      else $error("steal request after done");
   c_ack: cover property (O_IRQ_REQ && I_IRQ_ACK);
   c_steal: cover property (O_STEAL_REQ && I_STEAL_DONE);
   c_refuse: cover property (O_PREADY && O_PSLVERR);
endmodule : intc_checker

bind intc_top intc_checker intc_checker_inst (.I_REF_CLK, .I_RST, .I_PSEL, .I_PENABLE,
   .I_PADDR, .O_PREADY, .O_PSLVERR, .O_IRQ_REQ, .O_IRQ_TRAP, .O_IRQ_LEVEL, .I_IRQ_ACK,
   .I_SWTRAP_VALID, .O_SWTRAP_VALID, .O_STEAL_REQ, .O_STEAL_SRC, .O_STEAL_DST, .I_STEAL_DONE);

// ==== test/steal_responder.sv ====
// bus model that serves the cycle steal requests of the transfer engine
module steal_responder
   import intc_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // steal port
   input  wire logic        i_req,
   input  wire logic [23:0] i_src,
   input  wire logic [23:0] i_dst,
   input  wire logic        i_word,
   input  wire logic [3:0]  i_delay,
   output logic             o_done,
   // record of the last move
   output logic [48:0]      o_last,
   output logic [7:0]       o_moves
);
   logic [3:0] wait_cnt;

   // a nonzero delay models a slow bus; done is a single pulse
   always_ff @(posedge i_clk) begin
      o_done <= 1'b0;
      if (i_rst) begin
         o_moves <= 8'h00;
      end
      if (i_rst || !i_req || o_done) begin
         wait_cnt <= 4'h0;
      end else if (wait_cnt == i_delay) begin
         o_done  <= 1'b1;
         o_last  <= {i_word, i_src, i_dst};
         o_moves <= o_moves + 8'h01;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule : steal_responder

// ==== test/intc_top_test.sv ====
// self-checking testbench of the interrupt controller
module intc_top_test
   import intc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ack = 0, ret = 0, alt = 0;
   logic        swv = 0, pready, pslverr, irq, swo, sreq, sword, sdone, er;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [15:0] src = 0;
   logic [1:0]  pin = 0;
   logic [7:0]  swn = 0, trap, moves;
   logic [3:0]  dly = 0, lvl;
   logic [23:0] vec, swvec, ssrc, sdst;
   logic [48:0] last;
   int          n_fail = 0, tests_run = 0;

   always #4 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   // design and far side
   intc_top intc_top_inst (.I_REF_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
      .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
      .O_PRDATA(prdata), .O_PSLVERR(pslverr), .I_SRC_REQ(src), .I_ALT_REQ(alt),
      .I_EXT_PIN(pin), .O_IRQ_REQ(irq), .O_IRQ_VECTOR(vec), .O_IRQ_TRAP(trap),
      .O_IRQ_LEVEL(lvl), .I_IRQ_ACK(ack), .I_IRQ_RETURN(ret), .I_SWTRAP_VALID(swv),
      .I_SWTRAP_NUM(swn), .O_SWTRAP_VALID(swo), .O_SWTRAP_VECTOR(swvec),
      .O_STEAL_REQ(sreq), .O_STEAL_SRC(ssrc), .O_STEAL_DST(sdst), .O_STEAL_WORD(sword),
      .I_STEAL_DONE(sdone));
   steal_responder steal_responder_inst (.i_clk(clk), .i_rst(rst), .i_req(sreq),
      .i_src(ssrc), .i_dst(sdst), .i_word(sword), .i_delay(dly), .o_done(sdone),
      .o_last(last), .o_moves(moves));

   ////////////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // master holds the request until ready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      pen <= 0;
   endtask : apb

   task automatic rdk(input logic [11:0] a, input logic [31:0] d, input logic e);
      apb(0, a, 0);
      chk(rd, d);
      chk(er, e);
   endtask : rdk

   // waits for an offer, checks it and takes it
   task automatic offer(input logic [7:0] t, input logic [23:0] v, input logic [3:0] l);
      int n;
      n = 0;
      do @(posedge clk); while (irq !== 1'b1 && ++n < 20);
      chk(n < 11, 1);
      chk({trap, vec, lvl}, {t, v, l});
      ack <= 1;
      @(posedge clk);
      ack <= 0;
   endtask : offer

   task automatic ret1;
      @(posedge clk) ret <= 1;
      @(posedge clk) ret <= 0;
   endtask : ret1

   task automatic pulse(input logic [15:0] v);
      @(posedge clk) src <= v;
      @(posedge clk) src <= 0;
   endtask : pulse

   task automatic quiet;
      repeat (8) @(posedge clk);
      chk(irq, 0);
   endtask : quiet

   // one peripheral request on node five, then the recorded move
   task automatic xfer(input logic [7:0] m, input logic [48:0] e);
      int n;
      n = 0;
      pulse(16'h0020);
      while (moves !== m && n++ < 30) @(posedge clk);
      chk(last, e);
   endtask : xfer

   task automatic results;
      if (n_fail == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog, generous against the few hundred cycles the sequence needs
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      results();
   end

   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst <= 0;
      rdk(12'h040, 0, 0);
      rdk(12'h04c, 0, 1);
      apb(1, 12'h044, 32'h12);
      rdk(12'h044, 32'h12, 0);
      @(posedge clk) swn <= 8'h28;
      swv <= 1;
      @(posedge clk) swv <= 0;
      @(posedge clk) chk({swo, swvec}, {1'b1, 24'h1200a0});
      apb(1, 12'h00c, 32'hc5);
      offer(8'h13, 24'h12004c, 4'h5);
      apb(1, 12'h010, 32'hc5);
      quiet();
      apb(1, 12'h008, 32'hc9);
      offer(8'h12, 24'h120048, 4'h9);
      ret1();
      ret1();
      offer(8'h14, 24'h120050, 4'h5);
      ret1();
      apb(1, 12'h020, 32'h4c);
      apb(1, 12'h024, 32'h4c);
      pulse(16'h0300);
      offer(8'h18, 24'h120060, 4'hc);
      ret1();
      offer(8'h19, 24'h120064, 4'hc);
      ret1();
      apb(1, 12'h040, 32'h15);
      apb(1, 12'h000, 32'h4f);
      apb(1, 12'h038, 32'h41);
      @(posedge clk) pin <= 2'b01;
      offer(8'h10, 24'h120080, 4'hf);
      ret1();
      @(posedge clk) pin <= 2'b00;
      pulse(16'h4000);
      quiet();
      @(posedge clk) alt <= 1;
      @(posedge clk) alt <= 0;
      offer(8'h1e, 24'h1200f0, 4'h1);
      ret1();
      apb(1, 12'h0a0, 32'h1000);
      apb(1, 12'h0a4, 32'h2000);
      apb(1, 12'h0a8, 32'h2);
      apb(1, 12'h0ac, 32'h7);
      apb(1, 12'h014, 32'h543);
      xfer(8'h01, {1'b1, 24'h001000, 24'h002000});
      chk(irq, 0);
      dly <= 4'h5;
      xfer(8'h02, {1'b1, 24'h001002, 24'h002002});
      offer(8'h15, 24'h1200a8, 4'h3);
      rdk(12'h0a8, 0, 0);
      ret1();
      apb(1, 12'h0ac, 32'h9);
      xfer(8'h03, {1'b0, 24'h001004, 24'h002004});
      rdk(12'h0a0, 32'h1005, 0);
      rdk(12'h0a8, 0, 0);
      apb(1, 12'h040, 32'he0);
      apb(1, 12'h004, 32'h42);
      @(posedge clk) pin <= 2'b11;
      offer(8'h11, 24'h120044, 4'h2);
      ret1();
      @(posedge clk) pin <= 2'b00;
      offer(8'h10, 24'h120040, 4'hf);
      ret1();
      offer(8'h11, 24'h120044, 4'h2);
      ret1();
      results();
   end
endmodule : intc_top_test
